// >>> core/erf_params.svh
// Constants for the exception return and fault unit
`ifndef ERF_PARAMS_SVH
`define ERF_PARAMS_SVH
`define ERF_EXIT_UPPER      28'hFFFFFFF
`define ERF_EXIT_HND_MAIN   4'h1
`define ERF_EXIT_THR_MAIN   4'h9
`define ERF_EXIT_THR_PROC   4'hD
`define ERF_PRIO_W          3
`define ERF_PRIO_RST        3'h0
`define ERF_ADDR_W          32
`define ERF_ADDR_RST        32'h00000000
`define ERF_UFS_COPROCESSOR_ACCESS_FLAG        0
`define ERF_UFS_ILLEGAL_OPCODE_FLAG       1
`define ERF_UFS_BAD_EXECUTION_STATE_FLAG     2
`define ERF_UFS_BAD_RETURN_CODE_FLAG       3
`define ERF_UFS_MISALIGNED_ACCESS_FLAG     4
`define ERF_UFS_ZERO_DIVISOR_FLAG        5
`endif

// >>> core/erf_pkg.sv
// Types for the exception return and fault unit
package erf_pkg;
  // Fault class that the pipeline is currently servicing
  typedef enum logic [2:0] {
    ERF_CTX_THREAD,
    ERF_CTX_OTHER,
    ERF_CTX_MEM,
    ERF_CTX_BUS,
    ERF_CTX_USAGE,
    ERF_CTX_HARD,
    ERF_CTX_NMI
  } erf_ctx_t;

  // Raw fault events, one-cycle pulses from the pipeline and bus
  typedef struct packed {
    logic vec_bus_err;
    logic ifetch_viol;
    logic ifetch_xn;
    logic data_viol;
    logic stack_viol;
    logic unstack_viol;
    logic stack_bus_err;
    logic unstack_bus_err;
    logic prefetch_bus_err;
    logic data_bus_exact;
    logic data_bus_inexact;
    logic cop_access;
    logic illegal_opcode_flag_op;
    logic bad_isa;
    logic bad_continuation;
    logic unaligned;
    logic div_zero;
  } erf_events_t;

  // Per-class priority and handler enable
  typedef struct packed {
    logic [2:0] mem_prio;
    logic [2:0] bus_prio;
    logic [2:0] usage_prio;
    logic       mem_en;
    logic       bus_en;
    logic       usage_en;
  } erf_cfg_t;

  // Exception return request and decoded result
  typedef struct packed {
    logic        valid;
    logic        handler_mode;
    logic        load_multi_pc;
    logic        branch_reg;
    logic        load_word_pc;
    logic [31:0] value;
  } erf_ret_req_t;

  typedef struct packed {
    logic to_handler;
    logic use_process_stack;
  } erf_ret_res_t;
endpackage : erf_pkg

// >>> core/erf_sticky.sv
// Sticky cause flag with set-over-clear priority
`timescale 1ns/100ps
`default_nettype none
module erf_sticky #(
  parameter int W = 1
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  output logic      [W-1:0] o_flag
);
  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      o_flag <= '0;
    else
      o_flag <= (o_flag & ~i_clr) | i_set;
  end
endmodule // erf_sticky
`default_nettype wire

// >>> core/erf_fault_unit.sv
// Exception return decode, fault classification, escalation and lockup
`timescale 1ns/100ps
`default_nettype none
`include "erf_params.svh"
module erf_fault_unit
  import erf_pkg::*;
#(
  parameter int AW = `ERF_ADDR_W
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_srst,
  input  wire erf_pkg::erf_ret_req_t i_ret,
  input  wire erf_pkg::erf_events_t  i_evt,
  input  wire erf_pkg::erf_cfg_t     i_cfg,
  input  wire erf_pkg::erf_ctx_t     i_ctx,
  input  wire logic [2:0]       i_cur_prio,
  input  wire logic [AW-1:0]    i_fault_addr,
  input  wire logic             i_nmi,
  input  wire logic             i_dbg_halt,
  input  wire logic [1:0]       i_hard_clr,
  input  wire logic [3:0]       i_mem_clr,
  input  wire logic [4:0]       i_bus_clr,
  input  wire logic [5:0]       i_usage_clr,
  output erf_pkg::erf_ret_res_t o_ret_res,
  output logic                  o_ret_go,
  output logic                  o_take_hard,
  output logic                  o_take_mem,
  output logic                  o_take_bus,
  output logic                  o_take_usage,
  output logic [1:0]            o_hard_status,
  output logic [3:0]            o_mem_status,
  output logic [4:0]            o_bus_status,
  output logic [5:0]            o_usage_status,
  output logic [AW-1:0]         o_mem_addr,
  output logic [AW-1:0]         o_bus_addr,
  output logic                  o_lockup
);
  import erf_pkg::*;

  logic ret_code_seen;
  logic ret_trig;
  logic ret_valid_code;
  logic ret_bad;
  logic [1:0] hard_set;
  logic [3:0] mem_set;
  logic [4:0] bus_set;
  logic [5:0] usage_set;
  logic mem_any;
  logic bus_any;
  logic usage_any;
  logic mem_esc;
  logic bus_esc;
  logic usage_esc;
  logic hard_any;
  logic in_hard;
  // Remembers whether lockup began in the NMI handler
  logic lock_from_nmi_r;
  logic lock_from_nmi_nxt;
  logic lockup_nxt;

  // Only a value with every upper bit set is a return code; any other
  // counter load in handler mode is an ordinary branch and must not fault
  assign ret_code_seen =
    (i_ret.value[31:4] == `ERF_EXIT_UPPER);

  // Return is only recognised from handler mode on a counter load
  assign ret_trig = i_ret.valid && i_ret.handler_mode && ret_code_seen
                    && (i_ret.load_multi_pc || i_ret.branch_reg
                        || i_ret.load_word_pc);

  // Upper bits must be all ones; three low codes are legal
  always_comb
  begin
    ret_valid_code = 1'b0;
    if (i_ret.value[31:4] == `ERF_EXIT_UPPER)
    begin
      unique case (i_ret.value[3:0])
        `ERF_EXIT_HND_MAIN: ret_valid_code = 1'b1;
        `ERF_EXIT_THR_MAIN: ret_valid_code = 1'b1;
        `ERF_EXIT_THR_PROC: ret_valid_code = 1'b1;
        default:            ret_valid_code = 1'b0;
      endcase
    end
  end

  // Reserved code replaces the return with a usage fault
  assign ret_bad = ret_trig && !ret_valid_code;

  // Return decision, registered so the pipeline sees a clean pulse.
  // The result holds until the next legal return, so it may be read late.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_ret_go  <= 1'b0;
      o_ret_res <= '0;
    end
    else
    begin
      o_ret_go <= ret_trig && ret_valid_code && !o_lockup;
      if (ret_trig && ret_valid_code)
      begin
        o_ret_res.to_handler <=
          (i_ret.value[3:0] == `ERF_EXIT_HND_MAIN);
        o_ret_res.use_process_stack <=
          (i_ret.value[3:0] == `ERF_EXIT_THR_PROC);
      end
    end
  end

  // Memory management causes; no-execute applies even with protection off
  assign mem_set = {i_evt.unstack_viol,
                    i_evt.stack_viol,
                    i_evt.data_viol,
                    i_evt.ifetch_viol | i_evt.ifetch_xn};

  // Bus causes: exact, inexact, prefetch, unstack, stack
  assign bus_set = {i_evt.stack_bus_err,
                    i_evt.unstack_bus_err,
                    i_evt.prefetch_bus_err,
                    i_evt.data_bus_inexact,
                    i_evt.data_bus_exact};

  // Usage causes in fixed bit positions
  always_comb
  begin
    usage_set = '0;
    usage_set[`ERF_UFS_COPROCESSOR_ACCESS_FLAG]    = i_evt.cop_access;
    usage_set[`ERF_UFS_ILLEGAL_OPCODE_FLAG]   = i_evt.illegal_opcode_flag_op;
    usage_set[`ERF_UFS_BAD_EXECUTION_STATE_FLAG] = i_evt.bad_isa
                                  | i_evt.bad_continuation;
    usage_set[`ERF_UFS_BAD_RETURN_CODE_FLAG]   = ret_bad;
    usage_set[`ERF_UFS_MISALIGNED_ACCESS_FLAG] = i_evt.unaligned;
    usage_set[`ERF_UFS_ZERO_DIVISOR_FLAG]    = i_evt.div_zero;
  end

  assign mem_any   = |mem_set;
  assign bus_any   = |bus_set;
  assign usage_any = |usage_set;
  // Hard fault and NMI handlers sit above every configurable priority
  assign in_hard   = (i_ctx == ERF_CTX_HARD) || (i_ctx == ERF_CTX_NMI);

  // Escalate when disabled, when in own handler, or when not more urgent.
  // A numerically smaller priority is more urgent, so >= cannot preempt.
  always_comb
  begin
    mem_esc = mem_any && (!i_cfg.mem_en
      || i_ctx == ERF_CTX_MEM
      || (i_ctx != ERF_CTX_THREAD
          && i_cfg.mem_prio >= i_cur_prio)
      || in_hard);
    // Stacking error on entry to the bus handler still runs it
    bus_esc = bus_any && !(i_evt.stack_bus_err
                           && i_ctx == ERF_CTX_BUS
                           && bus_set[3:0] == 4'h0)
      && (!i_cfg.bus_en
          || i_ctx == ERF_CTX_BUS
          || (i_ctx != ERF_CTX_THREAD && i_cfg.bus_prio >= i_cur_prio)
          || in_hard);
    // Usage faults follow the same rules as memory faults
    usage_esc = usage_any && (!i_cfg.usage_en
      || i_ctx == ERF_CTX_USAGE
      || (i_ctx != ERF_CTX_THREAD && i_cfg.usage_prio >= i_cur_prio)
      || in_hard);
  end

  // Hard fault causes: vector read error and escalation
  assign hard_set = {mem_esc | bus_esc | usage_esc,
                     i_evt.vec_bus_err};
  // Any hard cause, direct or escalated, counts for dispatch and lockup
  assign hard_any = |hard_set;

  // Cause flags hold until software clears them
  erf_sticky #(.W(2)) u_hard_flags (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_set     (hard_set),
    .i_clr     (i_hard_clr),
    .o_flag    (o_hard_status)
  );

  erf_sticky #(.W(4)) u_mem_flags (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_set     (mem_set),
    .i_clr     (i_mem_clr),
    .o_flag    (o_mem_status)
  );

  erf_sticky #(.W(5)) u_bus_flags (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_set     (bus_set),
    .i_clr     (i_bus_clr),
    .o_flag    (o_bus_status)
  );

  erf_sticky #(.W(6)) u_usage_flags (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_set     (usage_set),
    .i_clr     (i_usage_clr),
    .o_flag    (o_usage_status)
  );

  // Address capture only for memory and bus classes. Inexact errors carry
  // no trustworthy address, so they leave the bus address alone.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_mem_addr <= `ERF_ADDR_RST;
      o_bus_addr <= `ERF_ADDR_RST;
    end
    else
    begin
      if (mem_any)
        o_mem_addr <= i_fault_addr;
      if (bus_any && !i_evt.data_bus_inexact)
        o_bus_addr <= i_fault_addr;
    end
  end

  // Handler dispatch; hard fault is never taken on top of itself
  // Nothing executes in lockup, so no handler is dispatched from it
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_take_hard  <= 1'b0;
      o_take_mem   <= 1'b0;
      o_take_bus   <= 1'b0;
      o_take_usage <= 1'b0;
    end
    else
    begin
      o_take_hard  <= hard_any && !in_hard && !o_lockup;
      o_take_mem   <= mem_any && !mem_esc && !o_lockup;
      o_take_bus   <= bus_any && !bus_esc && !o_lockup;
      o_take_usage <= usage_any && !usage_esc && !o_lockup;
    end
  end

  // Lockup entry and release
  // An NMI cannot rescue a lockup that the NMI handler itself caused
  always_comb
  begin
    lockup_nxt        = o_lockup;
    lock_from_nmi_nxt = lock_from_nmi_r;
    if (!o_lockup && hard_any && in_hard)
    begin
      lockup_nxt        = 1'b1;
      lock_from_nmi_nxt = (i_ctx == ERF_CTX_NMI);
    end
    else if (o_lockup
             && (i_dbg_halt || (i_nmi && !lock_from_nmi_r)))
    begin
      lockup_nxt        = 1'b0;
      lock_from_nmi_nxt = 1'b0;
    end
  end

  // Reset clears lockup
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_lockup        <= 1'b0;
      lock_from_nmi_r <= 1'b0;
    end
    else
    begin
      o_lockup        <= lockup_nxt;
      lock_from_nmi_r <= lock_from_nmi_nxt;
    end
  end
endmodule // erf_fault_unit
`default_nettype wire

// >>> tb/erf_fault_unit_asserts.sv
// Checker for the exception return and fault unit
`timescale 1ns/100ps
`default_nettype none
module erf_fault_unit_asserts
  import erf_pkg::*;
#(
  parameter int AW = 32
) (
  input wire logic                  i_sys_clk,
  input wire logic                  i_srst,
  input wire erf_pkg::erf_ret_req_t i_ret,
  input wire erf_pkg::erf_events_t  i_evt,
  input wire erf_pkg::erf_cfg_t     i_cfg,
  input wire erf_pkg::erf_ctx_t     i_ctx,
  input wire logic [AW-1:0]         i_fault_addr,
  input wire logic                  i_dbg_halt,
  input wire logic [5:0]            i_usage_clr,
  input wire erf_pkg::erf_ret_res_t o_ret_res,
  input wire logic                  o_ret_go,
  input wire logic                  o_take_hard,
  input wire logic                  o_take_usage,
  input wire logic [1:0]            o_hard_status,
  input wire logic [3:0]            o_mem_status,
  input wire logic [4:0]            o_bus_status,
  input wire logic [5:0]            o_usage_status,
  input wire logic [AW-1:0]         o_mem_addr,
  input wire logic [AW-1:0]         o_bus_addr,
  input wire logic                  o_lockup
);
  logic trig;
  logic legal;
  logic bus_only_inexact;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // Return request decode; reserved nibbles still count as triggers
  assign trig = i_ret.valid && i_ret.handler_mode && i_ret.value[31:4]
    == 28'hFFFFFFF && (i_ret.load_multi_pc || i_ret.branch_reg
    || i_ret.load_word_pc);
  assign legal = trig && (i_ret.value[3:0] inside {4'h1, 4'h9, 4'hD});
  assign bus_only_inexact = i_evt.data_bus_inexact && !i_evt.data_bus_exact
    && !i_evt.prefetch_bus_err && !i_evt.stack_bus_err
    && !i_evt.unstack_bus_err;
  ret_go_a: assert property (legal && !o_lockup |=> o_ret_go)
    else $error("legal return not performed");
  ret_res_a: assert property (o_ret_go
    |-> o_ret_res.to_handler == ($past(i_ret.value[3:0]) == 4'h1)
    && o_ret_res.use_process_stack == ($past(i_ret.value[3:0]) == 4'hD))
    else $error("bad return result");
  ret_gate_a: assert property (i_ret.valid && !legal
    |=> !o_ret_go) else $error("return taken without legal trigger");
  bad_code_a: assert property (trig && !legal
    |=> o_usage_status[3]) else $error("reserved code not flagged");
  plain_branch_a: assert property (i_ret.valid
    && i_ret.value[31:4] != 28'hFFFFFFF && !o_usage_status[3]
    |=> !o_usage_status[3]) else $error("ordinary branch faulted");
  vec_hard_a: assert property (i_evt.vec_bus_err
    |=> o_hard_status[0]) else $error("vector read error not flagged");
  data_mem_a: assert property (i_evt.data_viol
    |=> o_mem_status[1] && o_mem_addr == $past(i_fault_addr))
    else $error("data violation");
  inexact_a: assert property (bus_only_inexact
    |=> o_bus_status[1] && $stable(o_bus_addr))
    else $error("inexact bus error handling");
  escalate_a: assert property (i_evt.illegal_opcode_flag_op
    && !i_cfg.usage_en && !o_lockup && i_ctx == ERF_CTX_THREAD
    |=> o_hard_status[1] && o_take_hard && !o_take_usage)
    else $error("no escalation");
  sticky_flag_a: assert property (o_usage_status[5]
    && !i_usage_clr[5] |=> o_usage_status[5])
    else $error("flag lost without clear");
  lock_enter_a: assert property (i_ctx == ERF_CTX_HARD
    && i_evt.vec_bus_err |=> o_lockup) else $error("no lockup");
  lock_halt_a: assert property (o_lockup && i_dbg_halt
    |=> !o_lockup) else $error("halt did not release lockup");
endmodule // erf_fault_unit_asserts
bind erf_fault_unit erf_fault_unit_asserts #(.AW(AW)) u_chk (.*);
`default_nettype wire

// >>> tb/erf_pipe_model.sv
// Pipeline and bus model that issues fault events with their address
`timescale 1ns/100ps
`default_nettype none
module erf_pipe_model
  import erf_pkg::*;
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_srst,
  input  wire erf_pkg::erf_events_t i_fire,
  input  wire logic [31:0]          i_addr,
  output erf_pkg::erf_events_t      o_evt,
  output logic [31:0]               o_addr
);
  // Events last one cycle; the address is inverted between events so a
  // capture outside its event shows up as a wrong value
  always_ff @(posedge i_sys_clk)
  begin
    o_evt  <= i_srst ? '0 : i_fire;
    o_addr <= i_srst ? '0 : (|i_fire) ? i_addr : ~o_addr;
  end
endmodule // erf_pipe_model
`default_nettype wire

// >>> tb/erf_fault_unit_tb.sv
// Testbench for the exception return and fault unit
`timescale 1ns/100ps
`default_nettype none
module erf_fault_unit_tb;
  import erf_pkg::*;
  logic         i_sys_clk;
  logic         i_srst;
  logic         nmi;
  logic         halt;
  erf_ret_req_t ret;
  erf_ret_res_t res;
  erf_events_t  fire;
  erf_events_t  evt;
  erf_cfg_t     cfg;
  erf_ctx_t     ctx;
  logic [2:0]   prio;
  logic [31:0]  addr, faddr, maddr, baddr, lastb;
  logic [1:0]   hst, hclr;
  logic [3:0]   mst, mclr, code;
  wire  [3:0]   tk;
  logic [4:0]   bst, bclr;
  logic [5:0]   ust, uclr;
  logic [16:0]  expst;
  logic         go, lock;
  int           num_errors, total_checks, p;
  // Flag position in {hard,mem,bus,usage} status for each event bit
  int pos [17] = '{5, 4, 2, 2, 1, 0, 7, 6, 8, 9, 10, 14, 13, 12, 11, 11, 15};
  erf_fault_unit #(.AW(32)) dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_ret(ret), .i_evt(evt), .i_cfg(cfg), .i_ctx(ctx), .i_cur_prio(prio),
    .i_fault_addr(faddr), .i_nmi(nmi), .i_dbg_halt(halt), .i_hard_clr(hclr),
    .i_mem_clr(mclr), .i_bus_clr(bclr), .i_usage_clr(uclr), .o_ret_res(res),
    .o_ret_go(go), .o_take_hard(tk[3]), .o_take_mem(tk[2]),
    .o_take_bus(tk[1]), .o_take_usage(tk[0]), .o_hard_status(hst),
    .o_mem_status(mst), .o_bus_status(bst), .o_usage_status(ust),
    .o_mem_addr(maddr), .o_bus_addr(baddr), .o_lockup(lock));
  erf_pipe_model pm (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_fire(fire),
    .i_addr(addr), .o_evt(evt), .o_addr(faddr));
  // Clock at 100 MHz
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Context and configuration change one edge ahead of the event
  task automatic setup(input erf_ctx_t c, input logic [2:0] pr,
                       input erf_cfg_t g, input logic h, input logic n);
    @(posedge i_sys_clk);
    ctx  <= c;
    prio <= pr;
    cfg  <= g;
    halt <= h;
    nmi  <= n;
  endtask
  // Event reaches the unit through the model, one edge later
  task automatic pulse(input erf_events_t e, input logic [31:0] a);
    @(posedge i_sys_clk);
    fire <= e;
    addr <= a;
    @(posedge i_sys_clk);
    fire <= '0;
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic do_ret(input logic [31:0] v, input logic h,
                        input logic [2:0] t);
    @(posedge i_sys_clk);
    ret <= {1'b1, h, t, v};
    @(posedge i_sys_clk);
    ret <= '0;
    #1;
  endtask
  task automatic clear_all;
    @(posedge i_sys_clk);
    {hclr, mclr, bclr, uclr} <= '1;
    @(posedge i_sys_clk);
    {hclr, mclr, bclr, uclr} <= '0;
    #1;
    chk({hst, mst, bst, ust}, '0);
  endtask
  // Cuts a hang short
  initial
  begin
    #200000;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    {i_srst, nmi, halt, ret, fire, addr, prio} = '0;
    {hclr, mclr, bclr, uclr, num_errors, total_checks, lastb} = '0;
    i_srst = 1'b1;
    cfg = 12'h007;
    ctx = ERF_CTX_THREAD;
    repeat (16) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk({hst, mst, bst, ust, go, lock}, '0);
    chk(maddr, '0);
    chk(baddr, '0);
    for (int k = 0; k < 9; k++)
    begin
      code = (k % 3 == 0) ? 4'h1 : (k % 3 == 1) ? 4'h9 : 4'hD;
      do_ret({28'hFFFFFFF, code}, 1'b1, 3'b100 >> (k / 3));
      chk(go, 1'b1);
      chk(res, {code == 4'h1, code == 4'hD});
    end
    do_ret(32'hFFFFFFF9, 1'b0, 3'b010);
    chk(go, 1'b0);
    do_ret(32'hFFFFFFF9, 1'b1, 3'b000);
    chk(go, 1'b0);
    do_ret(32'h00000400, 1'b1, 3'b010);
    chk({go, ust, tk}, '0);
    do_ret(32'hFFFFFFF5, 1'b1, 3'b001);
    chk({go, ust[3], tk}, 6'b010001);
    clear_all();
    $display("test returns done");
    expst = '0;
    for (int i = 16; i >= 0; i--)
    begin
      p = pos[i];
      expst[p] = 1'b1;
      pulse(erf_events_t'(17'h1 << i), 32'h100 + i);
      if (p inside {6, 8, 9, 10})
        lastb = 32'h100 + i;
      chk({hst, mst}, expst[16:11]);
      chk({bst, ust}, expst[10:0]);
      chk(tk, p > 14 ? 8 : p > 10 ? 4 : p > 5 ? 2 : 1);
      chk(baddr, lastb);
      if (p inside {11, 12, 13, 14})
        chk(maddr, 32'h100 + i);
    end
    clear_all();
    $display("test classes done");
    setup(ERF_CTX_THREAD, 3'h0, 12'h006, 1'b0, 1'b0);
    pulse(17'h00010, 32'h0);
    chk({hst[1], tk}, 5'b11000);
    for (int j = 0; j < 2; j++)
    begin
      setup(ERF_CTX_OTHER, 3'h2, {3'h3 - 3'(2 * j), 9'h007}, 1'b0, 1'b0);
      pulse(17'h02000, 32'h40);
      chk(tk, j ? 4'h4 : 4'h8);
    end
    setup(ERF_CTX_MEM, 3'h1, {3'h1, 9'h007}, 1'b0, 1'b0);
    pulse(17'h02000, 32'h44);
    chk(tk, 4'h8);
    setup(ERF_CTX_BUS, 3'h2, 12'h087, 1'b0, 1'b0);
    pulse(17'h00400, 32'h48);
    chk(tk, 4'h2);
    clear_all();
    $display("test escalation done");
    for (int j = 0; j < 2; j++)
    begin
      setup(j ? ERF_CTX_NMI : ERF_CTX_HARD, 3'h0, 12'h007, 1'b0, 1'b0);
      pulse(17'h10000, 32'h0);
      chk({lock, tk}, 5'h10);
      do_ret(32'hFFFFFFF9, 1'b1, 3'b010);
      chk({go, tk}, '0);
      setup(ERF_CTX_THREAD, 3'h0, 12'h007, 1'b0, 1'b1);
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk(lock, j[0]);
      setup(ERF_CTX_THREAD, 3'h0, 12'h007, 1'b1, 1'b0);
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk(lock, 1'b0);
    end
    setup(ERF_CTX_THREAD, 3'h0, 12'h007, 1'b0, 1'b0);
    clear_all();
    $display("test lockup done");
    give_verdict();
  end
endmodule // erf_fault_unit_tb
`default_nettype wire
